// *** verilog/hfp_pkg.sv ***
`default_nettype none
package hfp_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_SCHED = 8'h00;
    localparam logic [7:0] OFS_CFG = 8'h04;
    localparam logic [7:0] OFS_ANA_CTRL2 = 8'h08;
    localparam logic [7:0] OFS_GATE_REQ = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_MASK = 8'h14;
    localparam logic [7:0] OFS_ANA_IN = 8'h18;
    localparam logic [7:0] OFS_LD_TIME = 8'h1c;
    localparam logic [7:0] OFS_LD_MAX = 8'h20;
    // Scheduled channels and status bits
    localparam int NCH = 4;
    localparam int CH_OCD1 = 0;
    localparam int CH_OCD2 = 1;
    localparam int CH_OCC = 2;
    localparam int CH_OT = 3;
    localparam int ST_SCC = 4;
    localparam int ST_SCD = 5;
    localparam int ST_PUMP_UNDERVOLTAGE_LOCKOUT = 6;
    localparam int ST_FUSE = 7;
    localparam int ST_LDTO = 8;
    localparam int ST_LDOK = 9;
    localparam int NST = 10;
    // Gate indices
    localparam int NG = 4;
    localparam int G_DSG = 0;
    localparam int G_CHG = 1;
    localparam int G_PREDISCHARGE_GATE = 2;
    localparam int G_PRECHARGE_GATE = 3;
    // Field positions
    localparam int SCHED_EN_BIT = 0;
    localparam int SCHED_CNT_LSB = 4;
    localparam int CNT_W = 4;
    localparam int FUSE_BLOW_BIT = 0;
    localparam int ANA_FUSE = 0;
    localparam int ANA_PUMP = 1;
    localparam int ANA_LD = 2;
    localparam int ANA_GATE_LSB = 4;
    localparam int LD_OFF_LSB = 16;
    localparam int CFG_W = 9;
    localparam logic [CNT_W-1:0] CNT_MIN = 4'h1;
    localparam logic [CNT_W-1:0] CNT_MAX = 4'h9;
    // Timing
    localparam int CLK_MHZ = 200;
    localparam int SLOT_NS = 500;
    localparam int SLOT_CYC = (SLOT_NS * CLK_MHZ + 999) / 1000;
    localparam int LD_TIME_W = 16;
    localparam int LD_MAX_W = 8;
    localparam logic [LD_TIME_W-1:0] LD_ON_RST = 16'h0064;
    localparam logic [LD_TIME_W-1:0] LD_OFF_RST = 16'h03e8;
    localparam logic [LD_MAX_W-1:0] LD_MAX_RST = 8'h10;

    typedef struct packed {
        logic host_discharge_off_input;
        logic host_charge_off_input;
        logic ld_above;
        logic fuse_pin;
        logic pump_ready;
        logic sc_dsg;
        logic sc_chg;
        logic cmp_hit;
    } hfp_pin_s;

    typedef struct packed {
        logic fuse_mon;
        logic ld_pu_en;
        logic ld_rec_en;
        logic pump_undervoltage_lockout_off;
        logic pump_undervoltage_lockout_en;
        logic [NG-1:0] ot_gates;
    } hfp_cfg_s;

    typedef enum logic [1:0] {LD_IDLE, LD_ON, LD_OFF} hfp_ld_e;

    typedef struct packed {
        hfp_ld_e st;
        logic [LD_TIME_W-1:0] cnt;
        logic [LD_MAX_W-1:0] per;
        logic src;
        logic ok;
        logic to;
    } hfp_ld_s;

    typedef struct packed {
        hfp_pin_s s1;
        hfp_pin_s s2;
        logic dp_wr;
        logic [7:0] dp_addr;
        logic [31:0] hrdata;
        logic hrdy;
        logic hresp;
        logic sched_en;
        logic [NCH*CNT_W-1:0] cnt_thr;
        hfp_cfg_s cfg;
        logic fuse_blow;
        logic [NG-1:0] gate_req;
        logic [NST-1:0] status;
        logic [NST-1:0] mask;
        logic [LD_TIME_W-1:0] ld_on;
        logic [LD_TIME_W-1:0] ld_off;
        logic [LD_MAX_W-1:0] ld_max;
        logic [1:0] slot;
        logic [7:0] dwell;
        logic [NCH*CNT_W-1:0] det_cnt;
        logic [NG-1:0] gate;
        logic pu_done;
        logic irq;
    } hfp_st_s;
endpackage : hfp_pkg
`default_nettype wire

// *** verilog/hfp_load_detect.sv ***
`timescale 1ns/1ps
`default_nettype none
module hfp_load_detect (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // Control
    input wire logic start_i,
    input wire logic ld_above_i,
    input wire logic [hfp_pkg::LD_TIME_W-1:0] on_cyc_i,
    input wire logic [hfp_pkg::LD_TIME_W-1:0] off_cyc_i,
    input wire logic [hfp_pkg::LD_MAX_W-1:0] max_per_i,
    // Status
    output logic src_en_o,
    output logic ok_o,
    output logic timeout_o,
    output logic busy_o
);
    hfp_pkg::hfp_ld_s st_reg;
    hfp_pkg::hfp_ld_s st_next;

    always_comb
    begin
        st_next = st_reg;
        st_next.ok = 1'b0;
        st_next.to = 1'b0;
        case (st_reg.st)
            hfp_pkg::LD_IDLE:
                if (start_i)
                begin
                    st_next.st = hfp_pkg::LD_ON;
                    st_next.cnt = on_cyc_i;
                    st_next.per = '0;
                    st_next.src = 1'b1;
                end
            hfp_pkg::LD_ON:
                // Pin level is judged at the end of each on window
                if (st_reg.cnt <= 16'h0001)
                begin
                    st_next.src = 1'b0;
                    if (ld_above_i)
                    begin
                        st_next.ok = 1'b1;
                        st_next.st = hfp_pkg::LD_IDLE;
                    end
                    else if (st_reg.per + 1'b1 >= max_per_i)
                    begin
                        st_next.to = 1'b1;
                        st_next.st = hfp_pkg::LD_IDLE;
                    end
                    else
                    begin
                        st_next.st = hfp_pkg::LD_OFF;
                        st_next.cnt = off_cyc_i;
                        st_next.per = st_reg.per + 1'b1;
                    end
                end
                else
                begin
                    st_next.cnt = st_reg.cnt - 1'b1;
                end
            hfp_pkg::LD_OFF:
                if (st_reg.cnt <= 16'h0001)
                begin
                    st_next.st = hfp_pkg::LD_ON;
                    st_next.cnt = on_cyc_i;
                    st_next.src = 1'b1;
                end
                else
                begin
                    st_next.cnt = st_reg.cnt - 1'b1;
                end
            default:
                st_next.st = hfp_pkg::LD_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            st_reg <= '0;
            st_reg.st <= hfp_pkg::LD_IDLE;
        end
        else if (ce_i)
        begin
            st_reg <= st_next;
        end
    end

    assign src_en_o = st_reg.src;
    assign ok_o = st_reg.ok;
    assign timeout_o = st_reg.to;
    assign busy_o = (st_reg.st != hfp_pkg::LD_IDLE);
endmodule : hfp_load_detect
`default_nettype wire

// *** verilog/hfp_protect.sv ***
// Our own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Shared comparator scheduler runs only while scheduler_enable_bit is one.
// - Scheduler rotates discharge overcurrent 1, 2, charge overcurrent, over-temperature.
// - Discharge faults drop discharge gates; charge fault drops charge gates; temperature configurable.
// - Each condition needs 1 to 9 consecutive positive detections.
// - Short circuit in either direction turns off all four gates.
// - Short circuit blocks turn-on until cleared; clearing turns nothing on.
// - Missing pump-ready indication counts as pump undervoltage lockout.
// - Lockout holds off or turns off gates as configured; can be disabled.
// - fuse_blow_bit drives fuse output; fuse pin readable in analog input status.
// - Fuse pin can be monitored for external activity when not driven.
// - Latched discharge faults with discharge gate off may recover on load removal.
// - Load detect pulses current source; recovery only when pin voltage is high.
// - Source alternates on and off durations until removal or timeout.
// - Optional load check at power-up before charge and discharge gates turn on.
// - Host force-off inputs are ORed with fault turn-off reasons.
module hfp_protect (
    // Clock, reset, enable
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic hready_i,
    input wire logic [31:0] hwdata_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Analog front-end pins
    input wire hfp_pkg::hfp_pin_s pins_i,
    output logic cmp_en_o,
    output logic [1:0] cmp_sel_o,
    output logic [hfp_pkg::NG-1:0] gate_o,
    output logic fuse_drive_o,
    output logic ld_src_en_o,
    // Interrupt
    output logic irq_o
);
    hfp_pkg::hfp_st_s st_reg;
    hfp_pkg::hfp_st_s st_next;
    logic slot_end;
    logic [hfp_pkg::NCH-1:0] det_hit;
    logic [hfp_pkg::NCH*hfp_pkg::CNT_W-1:0] cnt_nx;
    logic ld_start;
    logic ld_ok;
    logic ld_to;
    logic ld_busy;

    assign slot_end = st_reg.sched_en && (st_reg.dwell == 8'(hfp_pkg::SLOT_CYC - 1));

    // Consecutive detection counters, one per scheduled channel
    for (genvar i = 0; i < hfp_pkg::NCH; i++)
    begin : g_ch
        logic [hfp_pkg::CNT_W-1:0] raw;
        logic [hfp_pkg::CNT_W-1:0] thr;
        logic [hfp_pkg::CNT_W-1:0] cur;
        logic [hfp_pkg::CNT_W-1:0] inc;
        logic sample;
        assign raw = st_reg.cnt_thr[i*hfp_pkg::CNT_W +: hfp_pkg::CNT_W];
        assign thr = (raw < hfp_pkg::CNT_MIN) ? hfp_pkg::CNT_MIN :
                     (raw > hfp_pkg::CNT_MAX) ? hfp_pkg::CNT_MAX : raw;
        assign cur = st_reg.det_cnt[i*hfp_pkg::CNT_W +: hfp_pkg::CNT_W];
        assign inc = cur + 1'b1;
        assign sample = slot_end && (st_reg.slot == 2'(i));
        assign det_hit[i] = sample && st_reg.s2.cmp_hit && (inc >= thr);
        assign cnt_nx[i*hfp_pkg::CNT_W +: hfp_pkg::CNT_W] =
            !st_reg.sched_en ? '0 :
            !sample ? cur :
            !st_reg.s2.cmp_hit ? '0 :
            (inc >= thr) ? thr : inc;
    end

    hfp_load_detect u_ld (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .start_i(ld_start),
        .ld_above_i(st_reg.s2.ld_above),
        .on_cyc_i(st_reg.ld_on),
        .off_cyc_i(st_reg.ld_off),
        .max_per_i(st_reg.ld_max),
        .src_en_o(ld_src_en_o),
        .ok_o(ld_ok),
        .timeout_o(ld_to),
        .busy_o(ld_busy)
    );

    always_comb
    begin
        logic aphase;
        logic wr;
        logic [31:0] rd;
        logic [hfp_pkg::NST-1:0] set;
        logic [hfp_pkg::NST-1:0] clr;
        logic [hfp_pkg::NG-1:0] ot;
        logic [hfp_pkg::NG-1:0] off;
        logic sc_blk;
        logic discharge_overcurrent;
        logic uv;
        logic off_all;
        logic hold;
        aphase = 1'b0;
        wr = 1'b0;
        rd = '0;
        set = '0;
        clr = '0;
        ot = '0;
        off = '0;
        sc_blk = 1'b0;
        discharge_overcurrent = 1'b0;
        uv = 1'b0;
        off_all = 1'b0;
        hold = 1'b0;
        st_next = st_reg;
        ld_start = 1'b0;

        // Pin synchronisers
        st_next.s1 = pins_i;
        st_next.s2 = st_reg.s1;

        // Bus address phase, zero wait states, always OKAY
        aphase = hsel_i && htrans_i[1] && hready_i;
        st_next.dp_wr = aphase && hwrite_i;
        st_next.dp_addr = haddr_i[7:0];
        st_next.hrdy = 1'b1;
        st_next.hresp = 1'b0;
        case (haddr_i[7:0])
            hfp_pkg::OFS_SCHED:
            begin
                rd[hfp_pkg::SCHED_EN_BIT] = st_reg.sched_en;
                rd[hfp_pkg::SCHED_CNT_LSB +: hfp_pkg::NCH*hfp_pkg::CNT_W] = st_reg.cnt_thr;
            end
            hfp_pkg::OFS_CFG: rd[hfp_pkg::CFG_W-1:0] = st_reg.cfg;
            hfp_pkg::OFS_ANA_CTRL2: rd[hfp_pkg::FUSE_BLOW_BIT] = st_reg.fuse_blow;
            hfp_pkg::OFS_GATE_REQ: rd[hfp_pkg::NG-1:0] = st_reg.gate_req;
            hfp_pkg::OFS_STATUS: rd[hfp_pkg::NST-1:0] = st_reg.status;
            hfp_pkg::OFS_MASK: rd[hfp_pkg::NST-1:0] = st_reg.mask;
            hfp_pkg::OFS_ANA_IN:
            begin
                rd[hfp_pkg::ANA_FUSE] = st_reg.s2.fuse_pin;
                rd[hfp_pkg::ANA_PUMP] = st_reg.s2.pump_ready;
                rd[hfp_pkg::ANA_LD] = st_reg.s2.ld_above;
                rd[hfp_pkg::ANA_GATE_LSB +: hfp_pkg::NG] = st_reg.gate;
            end
            hfp_pkg::OFS_LD_TIME:
            begin
                rd[hfp_pkg::LD_TIME_W-1:0] = st_reg.ld_on;
                rd[hfp_pkg::LD_OFF_LSB +: hfp_pkg::LD_TIME_W] = st_reg.ld_off;
            end
            hfp_pkg::OFS_LD_MAX: rd[hfp_pkg::LD_MAX_W-1:0] = st_reg.ld_max;
            default: rd = '0;
        endcase
        st_next.hrdata = (aphase && !hwrite_i) ? rd : '0;

        // Bus data phase writes
        wr = st_reg.dp_wr;
        if (wr)
        begin
            case (st_reg.dp_addr)
                hfp_pkg::OFS_SCHED:
                begin
                    st_next.sched_en = hwdata_i[hfp_pkg::SCHED_EN_BIT];
                    st_next.cnt_thr =
                        hwdata_i[hfp_pkg::SCHED_CNT_LSB +: hfp_pkg::NCH*hfp_pkg::CNT_W];
                end
                hfp_pkg::OFS_CFG: st_next.cfg = hwdata_i[hfp_pkg::CFG_W-1:0];
                hfp_pkg::OFS_ANA_CTRL2: st_next.fuse_blow = hwdata_i[hfp_pkg::FUSE_BLOW_BIT];
                hfp_pkg::OFS_GATE_REQ:
                    if (!(st_reg.status[hfp_pkg::ST_SCC] || st_reg.status[hfp_pkg::ST_SCD]))
                    begin
                        st_next.gate_req = hwdata_i[hfp_pkg::NG-1:0];
                    end
                hfp_pkg::OFS_STATUS: clr = hwdata_i[hfp_pkg::NST-1:0];
                hfp_pkg::OFS_MASK: st_next.mask = hwdata_i[hfp_pkg::NST-1:0];
                hfp_pkg::OFS_LD_TIME:
                begin
                    st_next.ld_on = hwdata_i[hfp_pkg::LD_TIME_W-1:0];
                    st_next.ld_off = hwdata_i[hfp_pkg::LD_OFF_LSB +: hfp_pkg::LD_TIME_W];
                end
                hfp_pkg::OFS_LD_MAX: st_next.ld_max = hwdata_i[hfp_pkg::LD_MAX_W-1:0];
                default: st_next.fuse_blow = st_reg.fuse_blow;
            endcase
        end

        // Shared comparator slot rotation
        st_next.dwell = (!st_reg.sched_en || slot_end) ? '0 : st_reg.dwell + 1'b1;
        st_next.slot = !st_reg.sched_en ? '0 : slot_end ? st_reg.slot + 1'b1 : st_reg.slot;
        st_next.det_cnt = cnt_nx;

        // Event flags, set wins over clear
        uv = st_reg.cfg.pump_undervoltage_lockout_en && !st_reg.s2.pump_ready;
        set[hfp_pkg::NCH-1:0] = det_hit;
        set[hfp_pkg::ST_SCC] = st_reg.s2.sc_chg;
        set[hfp_pkg::ST_SCD] = st_reg.s2.sc_dsg;
        set[hfp_pkg::ST_PUMP_UNDERVOLTAGE_LOCKOUT] = uv;
        set[hfp_pkg::ST_FUSE] = st_reg.cfg.fuse_mon && !st_reg.fuse_blow
                                && st_reg.s2.fuse_pin;
        set[hfp_pkg::ST_LDTO] = ld_to;
        set[hfp_pkg::ST_LDOK] = ld_ok;
        if (ld_ok && st_reg.cfg.ld_rec_en)
        begin
            clr[hfp_pkg::CH_OCD1] = 1'b1;
            clr[hfp_pkg::CH_OCD2] = 1'b1;
            clr[hfp_pkg::ST_SCD] = 1'b1;
        end
        st_next.status = (st_reg.status & ~clr) | set;
        if (set[hfp_pkg::ST_SCC] || set[hfp_pkg::ST_SCD])
        begin
            st_next.gate_req = '0;
        end

        // Load detect launch for recovery or power-up check
        if (ld_ok)
        begin
            st_next.pu_done = 1'b1;
        end
        if (!st_reg.pu_done && |st_reg.gate_req && !st_reg.cfg.ld_pu_en)
        begin
            st_next.pu_done = 1'b1;
        end
        ld_start = !ld_busy && !st_next.status[hfp_pkg::ST_LDTO] && (
            (st_reg.cfg.ld_rec_en && !st_reg.gate[hfp_pkg::G_DSG] &&
             (st_next.status[hfp_pkg::CH_OCD1] || st_next.status[hfp_pkg::CH_OCD2] ||
              st_next.status[hfp_pkg::ST_SCD])) ||
            (!st_next.pu_done && st_reg.cfg.ld_pu_en && |st_reg.gate_req));

        // Gate decision
        sc_blk = st_next.status[hfp_pkg::ST_SCC] || st_next.status[hfp_pkg::ST_SCD];
        discharge_overcurrent = st_next.status[hfp_pkg::CH_OCD1] || st_next.status[hfp_pkg::CH_OCD2];
        ot = st_next.status[hfp_pkg::CH_OT] ? st_reg.cfg.ot_gates : '0;
        off[hfp_pkg::G_DSG] = discharge_overcurrent || ot[hfp_pkg::G_DSG]
                              || st_reg.s2.host_discharge_off_input;
        off[hfp_pkg::G_PREDISCHARGE_GATE] = discharge_overcurrent || ot[hfp_pkg::G_PREDISCHARGE_GATE]
                               || st_reg.s2.host_discharge_off_input;
        off[hfp_pkg::G_CHG] = st_next.status[hfp_pkg::CH_OCC] || ot[hfp_pkg::G_CHG]
                              || st_reg.s2.host_charge_off_input;
        off[hfp_pkg::G_PRECHARGE_GATE] = st_next.status[hfp_pkg::CH_OCC] || ot[hfp_pkg::G_PRECHARGE_GATE]
                               || st_reg.s2.host_charge_off_input;
        off_all = sc_blk || (uv && st_reg.cfg.pump_undervoltage_lockout_off) || !st_next.pu_done;
        hold = uv && !st_reg.cfg.pump_undervoltage_lockout_off;
        st_next.gate = st_next.gate_req & ~off & {hfp_pkg::NG{!off_all}}
                       & (st_reg.gate | {hfp_pkg::NG{!hold}});

        st_next.irq = |(st_next.status & st_next.mask);
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            st_reg <= '0;
            st_reg.hrdy <= 1'b1;
            st_reg.ld_on <= hfp_pkg::LD_ON_RST;
            st_reg.ld_off <= hfp_pkg::LD_OFF_RST;
            st_reg.ld_max <= hfp_pkg::LD_MAX_RST;
        end
        else if (ce_i)
        begin
            st_reg <= st_next;
        end
    end

    assign hrdata_o = st_reg.hrdata;
    assign hreadyout_o = st_reg.hrdy;
    assign hresp_o = st_reg.hresp;
    assign cmp_en_o = st_reg.sched_en;
    assign cmp_sel_o = st_reg.slot;
    assign gate_o = st_reg.gate;
    assign fuse_drive_o = st_reg.fuse_blow;
    assign irq_o = st_reg.irq;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (sys_rst_i);

    a_sched_idle: assert property (ce_i && !st_reg.sched_en |=> st_reg.det_cnt == '0)
        else $error("detect counters run while scheduler off");
    a_slot_rotate: assert property (ce_i && slot_end |=> cmp_sel_o == $past(cmp_sel_o) + 2'h1)
        else $error("slot did not advance");
    a_ocd_gates: assert property ((st_reg.status[0] || st_reg.status[1]) |->
        !gate_o[hfp_pkg::G_DSG] && !gate_o[hfp_pkg::G_PREDISCHARGE_GATE])
        else $error("discharge gate on during discharge overcurrent");
    a_occ_gates: assert property (st_reg.status[hfp_pkg::CH_OCC] |->
        !gate_o[hfp_pkg::G_CHG] && !gate_o[hfp_pkg::G_PRECHARGE_GATE])
        else $error("charge gate on during charge overcurrent");
    a_one_shot: assert property (ce_i && slot_end && cmp_sel_o == 2'h0 && st_reg.s2.cmp_hit
        && st_reg.cnt_thr[hfp_pkg::CNT_W-1:0] == hfp_pkg::CNT_MIN |=> st_reg.status[0])
        else $error("single detection not latched");
    a_sc_all_off: assert property ((st_reg.status[hfp_pkg::ST_SCC]
        || st_reg.status[hfp_pkg::ST_SCD]) |-> gate_o == '0)
        else $error("gate on during short circuit");
    a_sc_release: assert property ($fell(st_reg.status[hfp_pkg::ST_SCD])
        && !st_reg.status[hfp_pkg::ST_SCC] |-> gate_o == '0)
        else $error("clearing short circuit turned a gate on");
    a_pump_undervoltage_lockout_off: assert property (ce_i && st_reg.cfg.pump_undervoltage_lockout_en && st_reg.cfg.pump_undervoltage_lockout_off
        && !st_reg.s2.pump_ready |=> gate_o == '0)
        else $error("gate on during lockout");
    a_fuse_mon: assert property (ce_i && st_reg.cfg.fuse_mon && !fuse_drive_o
        && st_reg.s2.fuse_pin |=> st_reg.status[hfp_pkg::ST_FUSE])
        else $error("external fuse activity missed");
    a_host_off: assert property (ce_i && st_reg.s2.host_discharge_off_input |=>
        !gate_o[hfp_pkg::G_DSG] && !gate_o[hfp_pkg::G_PREDISCHARGE_GATE])
        else $error("host force-off ignored");
endmodule : hfp_protect
`default_nettype wire

// *** bench/hfp_far_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module hfp_far_model (
    // Device outputs
    input wire logic cmp_en_i,
    input wire logic [1:0] cmp_sel_i,
    input wire logic fuse_drive_i,
    input wire logic ld_src_en_i,
    // Pack conditions
    input wire logic [3:0] over_i,
    input wire logic [1:0] sc_i,
    input wire logic [1:0] host_off_i,
    input wire logic pump_ok_i,
    input wire logic load_gone_i,
    input wire logic ext_fuse_i,
    // Pins
    output var hfp_pkg::hfp_pin_s pins_o
);
    always_comb
    begin
        pins_o.cmp_hit = cmp_en_i & over_i[cmp_sel_i];
        pins_o.sc_chg = sc_i[0];
        pins_o.sc_dsg = sc_i[1];
        pins_o.pump_ready = pump_ok_i;
        pins_o.fuse_pin = fuse_drive_i | ext_fuse_i;
        pins_o.ld_above = ld_src_en_i & load_gone_i;
        pins_o.host_charge_off_input = host_off_i[0];
        pins_o.host_discharge_off_input = host_off_i[1];
    end
endmodule : hfp_far_model
`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic hready, hresp, cmp_en, fuse_drive, ld_src_en, irq;
    logic [1:0] cmp_sel;
    logic [3:0] gate;
    logic [3:0] over = 4'h0;
    logic [1:0] sc = 2'h0;
    logic [1:0] host_off = 2'h0;
    logic pump_ok = 1'b1;
    logic load_gone = 1'b0;
    logic ce = 1'b1;
    logic ext_fuse = 1'b0;
    hfp_pkg::hfp_pin_s pins;
    int miscompares = 0;
    int checked = 0;

    always #2.5 clk_sys_i = ~clk_sys_i;

    hfp_protect DUT (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ce_i(ce),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hready_i(hready), .hwdata_i(hwdata), .hrdata_o(hrdata),
        .hreadyout_o(hready), .hresp_o(hresp), .pins_i(pins), .cmp_en_o(cmp_en),
        .cmp_sel_o(cmp_sel), .gate_o(gate), .fuse_drive_o(fuse_drive),
        .ld_src_en_o(ld_src_en), .irq_o(irq));

    hfp_far_model FAR (.cmp_en_i(cmp_en), .cmp_sel_i(cmp_sel), .fuse_drive_i(fuse_drive),
        .ld_src_en_i(ld_src_en), .over_i(over), .sc_i(sc), .host_off_i(host_off),
        .pump_ok_i(pump_ok), .load_gone_i(load_gone), .ext_fuse_i(ext_fuse), .pins_o(pins));

    task automatic end_of_test();
        if (miscompares == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge clk_sys_i);
        while (hready !== 1'b1)
        begin
            @(posedge clk_sys_i);
        end
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk_sys_i);
        while (hready !== 1'b1)
        begin
            @(posedge clk_sys_i);
        end
        rd = hrdata;
    endtask : bus

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(what, e, rd & m);
    endtask : rdchk

    task automatic wait_gate(input logic [3:0] m, input logic [3:0] e);
        int n;
        n = 0;
        while ((gate & m) !== e && n < 2000)
        begin
            @(posedge clk_sys_i);
            n++;
        end
        chk("gate_o", {28'h0, e}, {28'h0, gate & m});
    endtask : wait_gate

    task automatic s_regs();
        rdchk("ld_time", hfp_pkg::OFS_LD_TIME, 32'hffffffff, 32'h03e80064);
        rdchk("ld_max", hfp_pkg::OFS_LD_MAX, 32'hffffffff, 32'h00000010);
        bus(1'b1, 8'h3c, 32'hffffffff);
        rdchk("unmapped", 8'h3c, 32'hffffffff, 32'h0);
    endtask : s_regs

    task automatic s_host();
        bus(1'b1, hfp_pkg::OFS_CFG, 32'h0);
        bus(1'b1, hfp_pkg::OFS_MASK, 32'h000003ff);
        bus(1'b1, hfp_pkg::OFS_GATE_REQ, 32'hf);
        wait_gate(4'hf, 4'hf);
        ce <= 1'b0;
        host_off <= 2'h2;
        repeat (10) @(posedge clk_sys_i);
        chk("gate_o", 32'hf, {28'h0, gate});
        ce <= 1'b1;
        wait_gate(4'h1, 4'h0);
        host_off <= 2'h1;
        wait_gate(4'h3, 4'h1);
        host_off <= 2'h0;
        wait_gate(4'hf, 4'hf);
    endtask : s_host

    task automatic s_short();
        sc <= 2'h2;
        wait_gate(4'hf, 4'h0);
        sc <= 2'h0;
        rdchk("status", hfp_pkg::OFS_STATUS, 32'h30, 32'h20);
        chk("irq_o", 32'h1, {31'h0, irq});
        bus(1'b1, hfp_pkg::OFS_STATUS, 32'h20);
        repeat (10) @(posedge clk_sys_i);
        chk("gate_o", 32'h0, {28'h0, gate});
        chk("irq_o", 32'h0, {31'h0, irq});
        bus(1'b1, hfp_pkg::OFS_GATE_REQ, 32'hf);
        wait_gate(4'hf, 4'hf);
    endtask : s_short

    task automatic s_sched_ld();
        over <= 4'h1;
        repeat (500) @(posedge clk_sys_i);
        chk("gate_o", 32'hf, {28'h0, gate});
        bus(1'b1, hfp_pkg::OFS_SCHED, 32'h00011111);
        wait_gate(4'hf, 4'ha);
        rdchk("status", hfp_pkg::OFS_STATUS, 32'hf, 32'h1);
        over <= 4'h0;
        bus(1'b1, hfp_pkg::OFS_SCHED, 32'h0);
        @(posedge clk_sys_i);
        chk("cmp_en_o", 32'h0, {31'h0, cmp_en});
        bus(1'b1, hfp_pkg::OFS_LD_TIME, 32'h00040004);
        bus(1'b1, hfp_pkg::OFS_CFG, 32'h40);
        repeat (100) @(posedge clk_sys_i);
        chk("gate_o", 32'ha, {28'h0, gate});
        load_gone <= 1'b1;
        wait_gate(4'hf, 4'hf);
        rdchk("status", hfp_pkg::OFS_STATUS, 32'h201, 32'h200);
        bus(1'b1, hfp_pkg::OFS_STATUS, 32'h3ff);
    endtask : s_sched_ld

    task automatic s_occ_ot();
        bus(1'b1, hfp_pkg::OFS_CFG, 32'h1);
        over <= 4'hc;
        bus(1'b1, hfp_pkg::OFS_SCHED, 32'h00013001);
        wait_gate(4'h1, 4'h0);
        rdchk("status", hfp_pkg::OFS_STATUS, 32'hc, 32'h8);
        wait_gate(4'hf, 4'h4);
        rdchk("status", hfp_pkg::OFS_STATUS, 32'hc, 32'hc);
        over <= 4'h0;
        bus(1'b1, hfp_pkg::OFS_SCHED, 32'h0);
        bus(1'b1, hfp_pkg::OFS_STATUS, 32'h3ff);
        wait_gate(4'hf, 4'hf);
    endtask : s_occ_ot

    task automatic s_fuse_pump_undervoltage_lockout();
        bus(1'b1, hfp_pkg::OFS_CFG, 32'h100);
        ext_fuse <= 1'b1;
        repeat (6) @(posedge clk_sys_i);
        ext_fuse <= 1'b0;
        rdchk("status", hfp_pkg::OFS_STATUS, 32'h80, 32'h80);
        bus(1'b1, hfp_pkg::OFS_STATUS, 32'h80);
        bus(1'b1, hfp_pkg::OFS_ANA_CTRL2, 32'h1);
        @(posedge clk_sys_i);
        chk("fuse_drive_o", 32'h1, {31'h0, fuse_drive});
        repeat (6) @(posedge clk_sys_i);
        rdchk("ana_in", hfp_pkg::OFS_ANA_IN, 32'h1, 32'h1);
        bus(1'b1, hfp_pkg::OFS_CFG, 32'h130);
        pump_ok <= 1'b0;
        wait_gate(4'hf, 4'h0);
        rdchk("status", hfp_pkg::OFS_STATUS, 32'hc0, 32'h40);
        pump_ok <= 1'b1;
        wait_gate(4'hf, 4'hf);
        bus(1'b1, hfp_pkg::OFS_CFG, 32'h10);
        pump_ok <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
        chk("gate_o", 32'hf, {28'h0, gate});
        pump_ok <= 1'b1;
    endtask : s_fuse_pump_undervoltage_lockout

    task automatic s_powerup();
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_sys_i);
        bus(1'b1, hfp_pkg::OFS_CFG, 32'h80);
        bus(1'b1, hfp_pkg::OFS_GATE_REQ, 32'hf);
        repeat (50) @(posedge clk_sys_i);
        chk("gate_o", 32'h0, {28'h0, gate});
        wait_gate(4'hf, 4'hf);
    endtask : s_powerup

    initial
    begin
        repeat (8) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_sys_i);
        s_regs();
        s_host();
        s_short();
        s_occ_ot();
        s_sched_ld();
        s_fuse_pump_undervoltage_lockout();
        s_powerup();
        end_of_test();
    end

    initial
    begin
        repeat (40000) @(posedge clk_sys_i);
        miscompares++;
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
